// File: src/ucsb_uart.sv
// Serial transceiver with control, status and baud registers on Wishbone.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// - Empty flag sets when held character moves into transmit shifter.
// - Data write clears empty flag; reset sets it.
// - Empty interrupt requests while flag and its enable are set.
// - Stop-bit error follows the sampled stop bit of each character stored; a character lost to overrun leaves it unchanged.
// - Overrun flag is buffered, visible after pending data is read.
// - Lossless transfer into receive register clears overrun.
// - Status bits two to zero read as zero.
// - Receive-done interrupt follows flag when its enable is set.
// - Transmit-done interrupt follows flag when its enable is set.
// - Receiver off blocks flag setting and keeps existing flags.
// - Transmitter off finishes shifter and pending characters first.
// - Nine-bit mode sends and receives nine data bits.
// - Received ninth bit lands in control bit one.
// - Bit rate is clock over sixteen times divisor plus one.
// - Divisor is an eight-bit read/write register.
// - Receive bits decided by majority of samples 8, 9, 10.
// - Frame is start zero, data LSB first, stop one.
// - Receive-done sets on transfer, clears on data read.
// - Transmit-done sets after stop bit time if no character is pending; write one clears.
module ucsb_uart (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        global_irq_en_i,
  input  wire logic        tx_done_vector_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             rx_done_irq_o,
  output logic             tx_done_irq_o,
  output logic             tx_empty_irq_o
);

  logic [7:0]  ctrl_reg;
  logic [7:0]  baud_reg;
  logic [7:0]  tx_hold_reg;
  logic        tx_hold_ninth_reg;
  logic [7:0]  rx_data_reg;
  logic        tx_empty_reg;
  logic        tx_done_reg;
  logic        rx_done_reg;
  logic        stop_err_reg;
  logic        overrun_reg;
  logic        overrun_pend_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        tick;
  logic        req;
  logic        wr;
  logic        rd_data;
  logic        baud_wr;

  assign req     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr      = req && wb_we_i && wb_sel_i[0];
  assign rd_data = req && !wb_we_i && wb_adr_i == ucsb_pkg::ADDR_DATA;
  assign baud_wr = wr && wb_adr_i == ucsb_pkg::ADDR_BAUD;

  ucsb_baud_gen #(
    .DIV_W(8)
  ) u_baud (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .divisor_i(baud_wr ? wb_dat_i[7:0] : baud_reg),
    .reload_i (baud_wr),
    .tick_o   (tick)
  );

  // Bus answer: one acknowledge, registered one cycle after the request, dropped the following cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end
  assign wb_ack_o = ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        ucsb_pkg::ADDR_DATA:    rdata_reg <= {24'h00_0000, rx_data_reg};
        ucsb_pkg::ADDR_STATUS:  rdata_reg <= {24'h00_0000, rx_done_reg,
          tx_done_reg, tx_empty_reg, stop_err_reg, overrun_reg,
          3'h0};
        ucsb_pkg::ADDR_CONTROL: rdata_reg <= {24'h00_0000, ctrl_reg};
        ucsb_pkg::ADDR_BAUD:    rdata_reg <= {24'h00_0000, baud_reg};
        default:                rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = rdata_reg;

  // Control bit one is owned by the receiver, not by software.
  logic       rx_ninth_load;
  logic       rx_ninth_val;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= ucsb_pkg::CONTROL_RESET;
    end else begin
      if (wr && wb_adr_i == ucsb_pkg::ADDR_CONTROL) begin
        ctrl_reg[7:2] <= wb_dat_i[7:2];
        ctrl_reg[ucsb_pkg::CT_TX_NINTH] <= wb_dat_i[ucsb_pkg::CT_TX_NINTH];
      end
      if (rx_ninth_load) begin
        ctrl_reg[ucsb_pkg::CT_RX_NINTH] <= rx_ninth_val;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_reg <= ucsb_pkg::BAUD_RESET;
    end else if (baud_wr) begin
      baud_reg <= wb_dat_i[7:0];
    end
  end

  // Transmitter.
  ucsb_pkg::ucsb_tx_state_e tx_state_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] tx_os_reg;
  logic [3:0] tx_bit_reg;
  logic       tx_load;
  logic       tx_bit_end;
  logic       tx_wr;
  logic       tx_stop_end;

  assign tx_wr      = wr && wb_adr_i == ucsb_pkg::ADDR_DATA;
  assign tx_bit_end = tick && tx_os_reg == ucsb_pkg::OVERSAMPLE_LAST;
  assign tx_stop_end = tx_state_reg == ucsb_pkg::UCSB_TX_STOP && tx_bit_end;
  // A pending character keeps going out even after the enable drops.
  // Loading on a tick keeps the start bit exactly sixteen ticks long.
  assign tx_load = !tx_empty_reg && (ctrl_reg[ucsb_pkg::CT_TX_ON] ||
                   tx_state_reg != ucsb_pkg::UCSB_TX_IDLE) &&
                   ((tx_state_reg == ucsb_pkg::UCSB_TX_IDLE && tick) ||
                    tx_stop_end);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold_reg       <= 8'h00;
      tx_hold_ninth_reg <= 1'b0;
    end else if (tx_wr) begin
      tx_hold_reg       <= wb_dat_i[7:0];
      tx_hold_ninth_reg <= ctrl_reg[ucsb_pkg::CT_TX_NINTH];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_reg <= 1'b1;
    end else if (tx_load) begin
      tx_empty_reg <= 1'b1;
    end else if (tx_wr) begin
      tx_empty_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= ucsb_pkg::UCSB_TX_IDLE;
      tx_shift_reg <= 9'h1ff;
      tx_os_reg    <= 4'h0;
      tx_bit_reg   <= 4'h0;
      txd_o        <= 1'b1;
    end else if (tx_load) begin
      tx_state_reg <= ucsb_pkg::UCSB_TX_START;
      tx_shift_reg <= {tx_hold_ninth_reg, tx_hold_reg};
      tx_os_reg    <= 4'h0;
      tx_bit_reg   <= 4'h0;
      txd_o        <= 1'b1;
    end else begin
      if (tick) begin
        tx_os_reg <= tx_os_reg + 4'h1;
      end
      case (tx_state_reg)
        ucsb_pkg::UCSB_TX_IDLE: begin
          txd_o     <= 1'b1;
          tx_os_reg <= 4'h0;
        end
        ucsb_pkg::UCSB_TX_START: begin
          txd_o <= 1'b0;
          if (tx_bit_end) begin
            tx_state_reg <= ucsb_pkg::UCSB_TX_DATA;
          end
        end
        ucsb_pkg::UCSB_TX_DATA: begin
          txd_o <= tx_shift_reg[0];
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            if (tx_bit_reg + 4'h1 == (ctrl_reg[ucsb_pkg::CT_NINE_BIT] ?
                ucsb_pkg::DATA_BITS_9 : ucsb_pkg::DATA_BITS_8)) begin
              tx_state_reg <= ucsb_pkg::UCSB_TX_STOP;
            end
          end
        end
        ucsb_pkg::UCSB_TX_STOP: begin
          txd_o <= 1'b1;
          if (tx_bit_end) begin
            tx_state_reg <= ucsb_pkg::UCSB_TX_IDLE;
          end
        end
        default: tx_state_reg <= ucsb_pkg::UCSB_TX_IDLE;
      endcase
    end
  end

  // Set wins over a simultaneous write-one clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_done_reg <= 1'b0;
    end else if (tx_stop_end && !tx_load) begin
      tx_done_reg <= 1'b1;
    end else if (tx_done_vector_i || (wr &&
                 wb_adr_i == ucsb_pkg::ADDR_STATUS &&
                 wb_dat_i[ucsb_pkg::ST_TX_DONE])) begin
      tx_done_reg <= 1'b0;
    end
  end

  // Receiver.
  ucsb_pkg::ucsb_rx_state_e rx_state_reg;
  logic [3:0] rx_os_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic [1:0] rx_votes_reg;
  logic       rx_vote;
  logic       rx_sample;
  logic       rx_decide;
  logic       rx_on;
  logic       rx_finish;
  logic [3:0] rx_nbits;

  assign rx_on     = ctrl_reg[ucsb_pkg::CT_RX_ON];
  assign rx_sample = tick && (rx_os_reg == ucsb_pkg::VOTE_SAMPLE_A ||
                     rx_os_reg == ucsb_pkg::VOTE_SAMPLE_B ||
                     rx_os_reg == ucsb_pkg::VOTE_SAMPLE_C);
  assign rx_decide = tick && rx_os_reg == ucsb_pkg::VOTE_SAMPLE_C;
  // Two of three samples high; the third sample is rxd_i itself.
  assign rx_vote   = (rx_votes_reg + {1'b0, rxd_i}) >= 2'd2;
  assign rx_nbits  = ctrl_reg[ucsb_pkg::CT_NINE_BIT] ?
                     ucsb_pkg::DATA_BITS_9 : ucsb_pkg::DATA_BITS_8;
  assign rx_finish = rx_state_reg == ucsb_pkg::UCSB_RX_STOP && rx_decide;

  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_on) begin
      rx_state_reg <= ucsb_pkg::UCSB_RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_votes_reg <= 2'd0;
    end else if (tick) begin
      rx_os_reg <= rx_os_reg + 4'h1;
      if (rx_sample && !rx_decide) begin
        rx_votes_reg <= rx_votes_reg + {1'b0, rxd_i};
      end
      if (rx_decide) begin
        rx_votes_reg <= 2'd0;
      end
      case (rx_state_reg)
        ucsb_pkg::UCSB_RX_IDLE: begin
          rx_os_reg <= 4'h1;
          if (!rxd_i) begin
            rx_state_reg <= ucsb_pkg::UCSB_RX_START;
          end
        end
        ucsb_pkg::UCSB_RX_START: begin
          if (rx_decide) begin
            rx_state_reg <= rx_vote ? ucsb_pkg::UCSB_RX_IDLE :
                            ucsb_pkg::UCSB_RX_DATA;
            rx_bit_reg   <= 4'h0;
          end
        end
        ucsb_pkg::UCSB_RX_DATA: begin
          if (rx_decide) begin
            rx_shift_reg <= ctrl_reg[ucsb_pkg::CT_NINE_BIT] ?
                            {rx_vote, rx_shift_reg[8:1]} :
                            {1'b0, rx_vote, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 4'h1;
            if (rx_bit_reg + 4'h1 == rx_nbits) begin
              rx_state_reg <= ucsb_pkg::UCSB_RX_STOP;
            end
          end
        end
        ucsb_pkg::UCSB_RX_STOP: begin
          if (rx_decide) begin
            rx_state_reg <= ucsb_pkg::UCSB_RX_IDLE;
          end
        end
        default: rx_state_reg <= ucsb_pkg::UCSB_RX_IDLE;
      endcase
    end
  end

  assign rx_ninth_load = rx_finish && (!rx_done_reg || rd_data) &&
                         ctrl_reg[ucsb_pkg::CT_NINE_BIT];
  assign rx_ninth_val  = rx_shift_reg[8];

  // A finished character is stored only when the previous one was read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_reg      <= 8'h00;
      rx_done_reg      <= 1'b0;
      stop_err_reg     <= 1'b0;
      overrun_reg      <= 1'b0;
      overrun_pend_reg <= 1'b0;
    end else begin
      if (rx_finish && (!rx_done_reg || rd_data)) begin
        rx_data_reg  <= rx_shift_reg[7:0];
        rx_done_reg  <= 1'b1;
        stop_err_reg <= !rx_vote;
        overrun_reg  <= overrun_pend_reg && rd_data;
        overrun_pend_reg <= 1'b0;
      end else begin
        if (rx_finish) begin
          overrun_pend_reg <= 1'b1;
        end else if (rd_data) begin
          rx_done_reg <= 1'b0;
          overrun_reg <= overrun_pend_reg;
        end
      end
    end
  end

  ucsb_pkg::ucsb_irq_s irq;
  assign irq = {rx_done_reg && ctrl_reg[ucsb_pkg::CT_RX_IRQ_EN],
                tx_done_reg && ctrl_reg[ucsb_pkg::CT_TX_IRQ_EN],
                tx_empty_reg && ctrl_reg[ucsb_pkg::CT_EMPTY_IRQ_EN]};

  assign rx_done_irq_o  = irq.rx_done && global_irq_en_i;
  assign tx_done_irq_o  = irq.tx_done && global_irq_en_i;
  assign tx_empty_irq_o = irq.tx_empty && global_irq_en_i;

endmodule : ucsb_uart

// File: src/ucsb_pkg.sv
// Package with register map, field positions, reset values and types.
package ucsb_pkg;

  // Register byte addresses on the Wishbone bus.
  localparam logic [3:0] ADDR_DATA    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_BAUD    = 4'hc;

  // Status register field positions.
  localparam int ST_RX_DONE   = 7;
  localparam int ST_TX_DONE   = 6;
  localparam int ST_TX_EMPTY  = 5;
  localparam int ST_STOP_ERR  = 4;
  localparam int ST_OVERRUN   = 3;

  // Control register field positions.
  localparam int CT_RX_IRQ_EN    = 7;
  localparam int CT_TX_IRQ_EN    = 6;
  localparam int CT_EMPTY_IRQ_EN = 5;
  localparam int CT_RX_ON        = 4;
  localparam int CT_TX_ON        = 3;
  localparam int CT_NINE_BIT     = 2;
  localparam int CT_RX_NINTH     = 1;
  localparam int CT_TX_NINTH     = 0;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET    = 8'h00;

  // Oversampling and majority-vote sample points.
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] VOTE_SAMPLE_A   = 4'h7;
  localparam logic [3:0] VOTE_SAMPLE_B   = 4'h8;
  localparam logic [3:0] VOTE_SAMPLE_C   = 4'h9;
  localparam logic [3:0] DATA_BITS_8     = 4'h8;
  localparam logic [3:0] DATA_BITS_9     = 4'h9;

  typedef enum logic [1:0] {
    UCSB_RX_IDLE  = 2'b00,
    UCSB_RX_START = 2'b01,
    UCSB_RX_DATA  = 2'b10,
    UCSB_RX_STOP  = 2'b11
  } ucsb_rx_state_e;

  typedef enum logic [1:0] {
    UCSB_TX_IDLE  = 2'b00,
    UCSB_TX_START = 2'b01,
    UCSB_TX_DATA  = 2'b10,
    UCSB_TX_STOP  = 2'b11
  } ucsb_tx_state_e;

  // Interrupt requests bundled together.
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic tx_empty;
  } ucsb_irq_s;

endpackage : ucsb_pkg

// File: src/ucsb_baud_gen.sv
// Baud divider producing the sixteen-times oversampling tick.
`timescale 1ns/1ps
module ucsb_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  input  wire logic             reload_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] count_reg;

  // A write restarts the count so the new rate applies at once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (reload_i || count_reg == '0) begin
      count_reg <= divisor_i;
    end else begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // One tick per reload gives clk / (divisor + 1) oversampling.
  assign tick_o = !rst_i && !reload_i && count_reg == '0;

endmodule : ucsb_baud_gen

// File: sim/ucsb_uart_props.sv
// Checker for bus timing, read-back, interrupt gating and bit timing.
`timescale 1ns/1ps
module ucsb_uart_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        global_irq_en_i,
  input wire logic        txd_o,
  input wire logic        rx_done_irq_o,
  input wire logic        tx_done_irq_o,
  input wire logic        tx_empty_irq_o
);
  logic [7:0] baud_sh;
  logic [7:0] ctrl_sh;
  logic       fresh;
  logic [9:0] low_run;
  // Shadows move at the edge where the design takes the request.
  wire        wr_ok = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                      wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_sh <= ucsb_pkg::BAUD_RESET;
      ctrl_sh <= ucsb_pkg::CONTROL_RESET;
      fresh   <= 1'b1;
    end else if (wr_ok) begin
      if (wb_adr_i == ucsb_pkg::ADDR_BAUD) baud_sh <= wb_dat_i[7:0];
      if (wb_adr_i == ucsb_pkg::ADDR_CONTROL) ctrl_sh <= wb_dat_i[7:0];
      if (wb_adr_i == ucsb_pkg::ADDR_DATA) fresh <= 1'b0;
    end
  end

  // Every bit is sixteen ticks, so any low run is a multiple of sixteen.
  always_ff @(posedge clk_i) begin
    if (rst_i || txd_o) low_run <= 10'h000;
    else low_run <= low_run + 10'h001;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_reserved_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == ucsb_pkg::ADDR_STATUS
    |-> wb_dat_o[2:0] == 3'h0) else $error("reserved bits set");
  chk_baud_readback: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == ucsb_pkg::ADDR_BAUD
    |-> wb_dat_o[7:0] == baud_sh) else $error("divisor read-back wrong");
  chk_irq_gated: assert property (!global_irq_en_i
    |-> !(rx_done_irq_o || tx_done_irq_o || tx_empty_irq_o))
    else $error("interrupt with global enable off");
  chk_rx_irq_en: assert property (
    !ctrl_sh[ucsb_pkg::CT_RX_IRQ_EN] |-> !rx_done_irq_o)
    else $error("receive interrupt without enable");
  chk_empty_fresh: assert property (
    fresh |-> tx_empty_irq_o ==
    (global_irq_en_i && ctrl_sh[ucsb_pkg::CT_EMPTY_IRQ_EN]))
    else $error("empty interrupt wrong before first write");
  chk_bit_length: assert property ($rose(txd_o)
    |-> low_run[3:0] == 4'h0) else $error("low run not whole bits");

  cover property ($fell(txd_o));
  cover property (rx_done_irq_o);
  cover property (tx_done_irq_o);
endmodule : ucsb_uart_props

bind ucsb_uart ucsb_uart_props chk_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .global_irq_en_i(global_irq_en_i), .txd_o(txd_o),
  .rx_done_irq_o(rx_done_irq_o), .tx_done_irq_o(tx_done_irq_o),
  .tx_empty_irq_o(tx_empty_irq_o));

// File: sim/ucsb_serial_peer.sv
// Remote serial transceiver model: sends and decodes frames.
`timescale 1ns/1ps
module ucsb_serial_peer #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int         nb = 8;
  int         n_got = 0;
  logic [9:0] got [16];
  logic [9:0] fr;

  // The line is pulled up, so it rests high outside frames.
  initial rxd_o = 1'b1;

  // An exact bit time keeps the rate error far below tolerance.
  task automatic send(input int n, input logic [8:0] d, input logic stp);
    @(posedge clk_i) rxd_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= d[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rxd_o <= stp;
    repeat (BIT_CLKS) @(posedge clk_i);
    rxd_o <= 1'b1;
    // One idle bit lets a false start after a low stop bit die out.
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask : send

  task automatic glitch(input int len);
    @(posedge clk_i) rxd_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask : glitch

  // Samples mid-bit on the falling clock edge, away from output changes.
  always begin
    @(negedge clk_i iff txd_i === 1'b0);
    fr = 10'h000;
    repeat (BIT_CLKS / 2) @(negedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(negedge clk_i);
      fr[i] = txd_i;
    end
    repeat (BIT_CLKS) @(negedge clk_i);
    fr[9] = txd_i;
    got[n_got % 16] = fr;
    n_got++;
  end
endmodule : ucsb_serial_peer

// File: sim/testbench.sv
// Bench for the serial transceiver: register table, frames both ways.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic       w;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ucsb_row_s;
  localparam ucsb_row_s ROWS [8] = '{'{1'b0, 4'h4, 8'h00, 8'h20},
    '{1'b0, 4'h8, 8'h00, 8'h00}, '{1'b0, 4'hc, 8'h00, 8'h00},
    '{1'b1, 4'hc, 8'ha5, 8'ha5}, '{1'b1, 4'h1, 8'hff, 8'h00},
    '{1'b1, 4'h8, 8'hff, 8'hfd}, '{1'b1, 4'h8, 8'h18, 8'h18},
    '{1'b1, 4'hc, 8'h01, 8'h01}};

  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        global_irq_en_i, tx_done_vector_i, rxd_i, txd_o;
  logic        rx_done_irq_o, tx_done_irq_o, tx_empty_irq_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0]  rd;
  logic [3:0]  sel_nxt = 4'h1;
  int          error_cnt = 0, cmp_count = 0, cyc_cnt = 0;

  ucsb_uart DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .global_irq_en_i(global_irq_en_i),
    .tx_done_vector_i(tx_done_vector_i), .rxd_i(rxd_i), .txd_o(txd_o),
    .rx_done_irq_o(rx_done_irq_o), .tx_done_irq_o(tx_done_irq_o),
    .tx_empty_irq_o(tx_empty_irq_o));
  // The last row sets divisor 1, so one bit is 32 clocks.
  ucsb_serial_peer #(.BIT_CLKS(32)) peer (.clk_i(clk_i), .txd_i(txd_o),
    .rxd_o(rxd_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [9:0] s, logic [9:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // The request stands until ack is sampled high at a rising edge.
  task automatic bus(input logic w, input logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= sel_nxt;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Ending on a falling edge lets callers look at settled outputs.
    @(negedge clk_i);
  endtask : bus

  task automatic rdc(string nm, logic [3:0] a, logic [7:0] e, logic [7:0] m);
    bus(1'b0, a, 8'h00);
    chk(nm, rd & m, e);
  endtask : rdc

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, global_irq_en_i, tx_done_vector_i} = '0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) bus(1'b1, ROWS[i].a, ROWS[i].d);
      rdc("row", ROWS[i].a, ROWS[i].e, 8'hff);
    end
    // A write without its low byte lane selected must be ignored.
    sel_nxt = 4'h0;
    bus(1'b1, 4'hc, 8'h77);
    sel_nxt = 4'h1;
    rdc("sel", 4'hc, 8'h01, 8'hff);
    $display("test registers done");
    @(posedge clk_i) global_irq_en_i <= 1'b1;
    bus(1'b1, 4'h8, 8'h38);
    chk("empty irq", tx_empty_irq_o, 1'b1);
    bus(1'b1, 4'h0, 8'ha5);
    bus(1'b1, 4'h0, 8'h5a);
    rdc("empty", 4'h4, 8'h00, 8'h20);
    chk("empty irq", tx_empty_irq_o, 1'b0);
    wait (peer.n_got >= 2);
    chk("frame", peer.got[0], 10'h2a5);
    chk("frame", peer.got[1], 10'h25a);
    repeat (48) @(negedge clk_i);
    rdc("txdone", 4'h4, 8'h60, 8'h60);
    bus(1'b1, 4'h4, 8'h40);
    rdc("txclr", 4'h4, 8'h00, 8'h40);
    peer.nb = 9;
    bus(1'b1, 4'h8, 8'h5d);
    bus(1'b1, 4'h0, 8'h3c);
    wait (peer.n_got >= 3);
    chk("nine", peer.got[2], 10'h33c);
    repeat (48) @(negedge clk_i);
    chk("txc irq", tx_done_irq_o, 1'b1);
    @(posedge clk_i) tx_done_vector_i <= 1'b1;
    @(posedge clk_i) tx_done_vector_i <= 1'b0;
    @(negedge clk_i);
    chk("txc vec", tx_done_irq_o, 1'b0);
    bus(1'b1, 4'h0, 8'hc3);
    bus(1'b1, 4'h0, 8'h81);
    bus(1'b1, 4'h8, 8'h55);
    wait (peer.n_got >= 5);
    chk("drain", peer.got[3], 10'h3c3);
    chk("drain", peer.got[4], 10'h381);
    $display("test transmit done");
    peer.send(9, 9'h1e7, 1'b1);
    rdc("ninth", 4'h8, 8'h02, 8'h02);
    rdc("rxdata", 4'h0, 8'he7, 8'hff);
    rdc("rxclr", 4'h4, 8'h00, 8'h80);
    bus(1'b1, 4'h8, 8'h90);
    peer.send(8, 9'h096, 1'b0);
    chk("rxc irq", rx_done_irq_o, 1'b1);
    rdc("ferr", 4'h4, 8'h90, 8'h98);
    rdc("rxdata", 4'h0, 8'h96, 8'hff);
    peer.send(8, 9'h011, 1'b1);
    peer.send(8, 9'h022, 1'b1);
    rdc("orpend", 4'h4, 8'h80, 8'h98);
    rdc("rxdata", 4'h0, 8'h11, 8'hff);
    rdc("orseen", 4'h4, 8'h08, 8'h08);
    peer.send(8, 9'h033, 1'b1);
    rdc("orclr", 4'h4, 8'h80, 8'h88);
    rdc("rxdata", 4'h0, 8'h33, 8'hff);
    peer.glitch(6);
    repeat (600) @(negedge clk_i);
    rdc("noise", 4'h4, 8'h00, 8'h80);
    // Flags raised before the receiver is switched off must stay.
    peer.send(8, 9'h044, 1'b0);
    bus(1'b1, 4'h8, 8'h00);
    peer.send(8, 9'h055, 1'b0);
    rdc("rxoff", 4'h4, 8'h90, 8'h98);
    rdc("rxkeep", 4'h0, 8'h44, 8'hff);
    $display("test receive done");
    report_and_stop();
  end
endmodule : testbench
